// ==== design/aarc_pkg.sv ====
`default_nettype none
package aarc_pkg;
	localparam int unsigned CLK_NS      = 50;
	localparam int unsigned SEC_NS      = 1_000_000_000;
	localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_NS;

	localparam int AW    = 8;
	localparam int DW    = 32;
	localparam int CW    = 16;
	localparam int ST_W  = 6;
	localparam int AVG_DEPTH = 32;
	localparam int SUM_W = CW + 5;

	localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
	localparam logic [AW-1:0] OFS_DOSET = 8'h04;
	localparam logic [AW-1:0] OFS_HIGH  = 8'h08;
	localparam logic [AW-1:0] OFS_LOW   = 8'h0C;
	localparam logic [AW-1:0] OFS_AVGL  = 8'h10;
	localparam logic [AW-1:0] OFS_WDOG  = 8'h14;
	localparam logic [AW-1:0] OFS_NODE  = 8'h18;
	localparam logic [AW-1:0] OFS_VSCH  = 8'h1C;
	localparam logic [AW-1:0] OFS_TIME  = 8'h20;
	localparam logic [AW-1:0] OFS_CMD   = 8'h24;
	localparam logic [AW-1:0] OFS_STAT  = 8'h28;
	localparam logic [AW-1:0] OFS_MASK  = 8'h2C;
	localparam logic [AW-1:0] OFS_FLT   = 8'h30;
	localparam logic [AW-1:0] OFS_AVG   = 8'h34;

	localparam int CTRL_DVAL = 0;
	localparam int CTRL_GM   = 1;
	localparam int CTRL_PM   = 3;
	localparam int VSCH_ST   = 8;
	localparam int CMD_SCRUB = 0;
	localparam int CMD_VCAN  = 1;

	localparam logic [1:0] GM_LATCH = 2'h0;
	localparam logic [1:0] GM_NONL  = 2'h1;
	localparam logic [1:0] GM_RESET = 2'h2;
	localparam logic [1:0] PM_OFF   = 2'h0;
	localparam logic [1:0] PM_RTU_B = 2'h2;

	localparam int FB_ANY = 1, FB_CLOW = 12, FB_CHIGH = 13;
	localparam int FB_VAL1 = 20, FB_VAL2 = 21, FB_SCRUB = 27;
	localparam int ST_HIGH = 0, ST_LOW = 1, ST_SCRUB = 2;
	localparam int ST_VSTART = 3, ST_KPTO = 4, ST_GDROP = 5;

	localparam logic [7:0]  FC_RD     = 8'h03;
	localparam logic [7:0]  FC_WR1    = 8'h06;
	localparam logic [7:0]  FC_WRN    = 8'h10;
	localparam logic [7:0]  NODE_MIN  = 8'h01;
	localparam logic [7:0]  NODE_MAX  = 8'hFA;
	localparam logic [7:0]  WDOG_MIN  = 8'h05;
	localparam logic [7:0]  WDOG_RST  = 8'h3C;
	localparam logic [7:0]  SCRUB_PCT = 8'h05;
	localparam logic [31:0] DOSET_RST = 32'h0000_2000;
	localparam logic [2:0]  AVGL_RST  = 3'h4;
	localparam logic [2:0]  AVGL_MAX  = 3'h5;
	localparam logic [5:0]  SEC_PER_MIN = 6'h3C;
	localparam logic [10:0] MIN_PER_DAY = 11'h5A0;

	typedef struct packed {
		logic        daily_en;
		logic [1:0]  gmode;
		logic [1:0]  proto;
		logic [31:0] do_setup;
		logic [CW-1:0] high_sp;
		logic [CW-1:0] low_sp;
		logic [2:0]  avg_log;
		logic [7:0]  wdog;
		logic [7:0]  node;
		logic [7:0]  val_int;
		logic [10:0] val_start;
	} aarc_cfg_t;

	typedef struct packed {
		logic       vld;
		logic [7:0] node;
		logic [7:0] func;
	} aarc_req_t;

	function automatic logic aarc_hit(input logic [AW-1:0] a,
		input logic [AW-1:0] o);
		return a == o;
	endfunction

	function automatic logic aarc_fc_ok(input logic [7:0] f);
		return (f == FC_RD) || (f == FC_WR1) || (f == FC_WRN);
	endfunction
endpackage
`default_nettype wire

// ==== design/aarc_avg.sv ====
`timescale 1ns/1ns
`default_nettype none
module aarc_avg (
	input  wire logic          i_core_clk,
	input  wire logic          i_rst_b,
	input  wire logic          i_ce,
	input  wire logic          i_flush,
	input  wire logic          i_vld,
	input  wire logic [15:0]   i_smp,
	input  wire logic [2:0]    i_log,
	output logic      [15:0]   o_avg,
	output logic               o_upd
);
	import aarc_pkg::*;

	logic [CW-1:0]    mem [AVG_DEPTH];
	logic [4:0]       wptr, next_wptr;
	logic [5:0]       fill, next_fill;
	logic [SUM_W-1:0] sum, next_sum;
	logic [15:0]      next_avg;
	logic [5:0]       n;
	logic [CW-1:0]    old;

	// window n = 2**log; while filling, nothing drops out yet
	always_comb begin
		n         = 6'h01 << i_log;
		old       = (fill >= n) ? mem[wptr - n[4:0]] : 16'h0000;
		next_wptr = wptr;
		next_fill = fill;
		next_sum  = sum;
		if (i_flush) begin
			next_fill = 6'h00;
			next_sum  = '0;
		end else if (i_vld) begin
			next_wptr = wptr + 5'h01;
			next_fill = (fill == 6'h20) ? fill : fill + 6'h01;
			next_sum  = sum + {5'h00, i_smp} - {5'h00, old};
		end
		next_avg = 16'(next_sum >> i_log);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr  <= 5'h00;
			fill  <= 6'h00;
			sum   <= '0;
			o_avg <= 16'h0000;
			o_upd <= 1'b0;
		end else if (i_ce) begin
			wptr  <= next_wptr;
			fill  <= next_fill;
			sum   <= next_sum;
			o_avg <= next_avg;
			o_upd <= i_vld & ~i_flush;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_ce && i_vld && !i_flush) begin
			mem[wptr] <= i_smp;
		end
	end
endmodule // aarc_avg
`default_nettype wire

// ==== design/aarc_top.sv ====
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module aarc_top #(
	parameter int unsigned P_CYC_PER_SEC = aarc_pkg::CYC_PER_SEC
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_ce,
	input  wire logic [aarc_pkg::AW-1:0] i_addr,
	input  wire logic [aarc_pkg::DW-1:0] i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	input  wire logic [31:0]             i_fault,
	input  wire logic                    i_smp_vld,
	input  wire logic [15:0]             i_smp,
	input  wire logic [7:0]              i_scrub_pct,
	input  wire logic [15:0]             i_scrub_days,
	input  wire logic [1:0]              i_val_fail,
	input  wire logic                    i_on_menu,
	input  wire aarc_pkg::aarc_req_t     i_req,
	output logic      [aarc_pkg::DW-1:0] o_rdata,
	output logic                         o_assign_relay,
	output logic                         o_gen_relay,
	output logic      [15:0]             o_avg,
	output logic                         o_val_start,
	output logic                         o_kp_timeout,
	output logic                         o_scrub_restart,
	output logic                         o_req_ack,
	output logic                         o_generic_out,
	output logic                         o_rtu_variant,
	output logic                         o_irq
);
	import aarc_pkg::*;

	aarc_cfg_t       cfg, next_cfg;
	logic [ST_W-1:0] irq_mask, next_irq_mask;
	logic [ST_W-1:0] sts, next_sts, sts_set;
	logic [DW-1:0]   next_rdata;
	logic            we;
	logic            gen_rst_p, scrub_new_p, vcancel_p, avg_flush;
	logic            tod_wr;

	logic [31:0] psc, next_psc;
	logic [5:0]  sec, next_sec;
	logic [10:0] tod, next_tod;
	logic [7:0]  days, next_days;
	logic [7:0]  wd, next_wd;
	logic        sec_tick, min_tick;
	logic        next_val_start, next_kp_to;

	logic        hi, next_hi, lo, next_lo;
	logic        scrub, next_scrub;
	logic [1:0]  vflag, next_vflag;
	logic        glat, next_glat;
	logic        next_gen_relay, next_assign_relay;
	logic [31:0] fv;
	logic        any_flt;
	logic        avg_upd;

	// only an enabled write counts, so a frozen block misses nothing twice
	assign we = i_wr & i_ce;

	aarc_avg u_avg (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_ce       (i_ce),
		.i_flush    (avg_flush),
		.i_vld      (i_smp_vld),
		.i_smp      (i_smp),
		.i_log      (cfg.avg_log),
		.o_avg      (o_avg),
		.o_upd      (avg_upd)
	);

	// configuration writes
	always_comb begin
		next_cfg      = cfg;
		next_irq_mask = irq_mask;
		gen_rst_p     = 1'b0;
		scrub_new_p   = 1'b0;
		vcancel_p     = 1'b0;
		avg_flush     = 1'b0;
		tod_wr        = 1'b0;
		if (we) begin
			if (aarc_hit(i_addr, OFS_CTRL)) begin
				next_cfg.daily_en = i_wdata[CTRL_DVAL];
				if (i_wdata[CTRL_GM+:2] == GM_RESET) begin
					gen_rst_p = 1'b1;
				end else if (i_wdata[CTRL_GM+:2] <= GM_NONL) begin
					next_cfg.gmode = i_wdata[CTRL_GM+:2];
				end
				if (i_wdata[CTRL_PM+:2] <= PM_RTU_B) begin
					next_cfg.proto = i_wdata[CTRL_PM+:2];
				end
			end
			if (aarc_hit(i_addr, OFS_DOSET)) begin
				next_cfg.do_setup = i_wdata;
			end
			if (aarc_hit(i_addr, OFS_HIGH)) begin
				next_cfg.high_sp = i_wdata[CW-1:0];
			end
			if (aarc_hit(i_addr, OFS_LOW)) begin
				next_cfg.low_sp = i_wdata[CW-1:0];
			end
			if (aarc_hit(i_addr, OFS_AVGL) && i_wdata[2:0] <= AVGL_MAX) begin
				next_cfg.avg_log = i_wdata[2:0];
				avg_flush        = 1'b1;
			end
			if (aarc_hit(i_addr, OFS_WDOG)) begin
				next_cfg.wdog = i_wdata[7:0];
			end
			if (aarc_hit(i_addr, OFS_NODE) && i_wdata[7:0] >= NODE_MIN &&
				i_wdata[7:0] <= NODE_MAX && i_wdata[31:8] == 24'h000000) begin
				next_cfg.node = i_wdata[7:0];
			end
			if (aarc_hit(i_addr, OFS_VSCH) &&
				i_wdata[VSCH_ST+:11] < MIN_PER_DAY) begin
				next_cfg.val_int   = i_wdata[7:0];
				next_cfg.val_start = i_wdata[VSCH_ST+:11];
			end
			tod_wr = aarc_hit(i_addr, OFS_TIME) && i_wdata[10:0] < MIN_PER_DAY;
			if (aarc_hit(i_addr, OFS_CMD)) begin
				scrub_new_p = i_wdata[CMD_SCRUB];
				vcancel_p   = i_wdata[CMD_VCAN];
			end
			if (aarc_hit(i_addr, OFS_MASK)) begin
				next_irq_mask = i_wdata[ST_W-1:0];
			end
		end
	end

	// time of day, validation schedule, keypad watchdog
	always_comb begin
		sec_tick = (psc == 32'(P_CYC_PER_SEC - 1));
		min_tick = sec_tick && (sec == SEC_PER_MIN - 6'h01);
		next_psc = sec_tick ? 32'h0000_0000 : psc + 32'h0000_0001;
		next_sec = min_tick ? 6'h00 : (sec_tick ? sec + 6'h01 : sec);
		next_tod = tod;
		if (min_tick) begin
			next_tod = (tod == MIN_PER_DAY - 11'h001) ? 11'h000 : tod + 11'h001;
		end
		next_days      = days;
		next_val_start = 1'b0;
		if (!cfg.daily_en) begin
			next_days = 8'h00;
		end else if (min_tick && next_tod == cfg.val_start) begin
			// an interval of 0 is taken as every day
			if (days + 8'h01 >= cfg.val_int) begin
				next_val_start = 1'b1;
				next_days      = 8'h00;
			end else begin
				next_days = days + 8'h01;
			end
		end
		if (tod_wr) begin
			next_tod = i_wdata[10:0];
			next_sec = 6'h00;
			next_psc = 32'h0000_0000;
		end
		next_wd    = wd;
		next_kp_to = 1'b0;
		if (!i_on_menu) begin
			next_wd = 8'h00;
		end else if (sec_tick) begin
			next_wd = (wd == 8'hFF) ? wd : wd + 8'h01;
			if (cfg.wdog >= WDOG_MIN && wd + 8'h01 == cfg.wdog) begin
				next_kp_to = 1'b1;
				next_wd    = 8'h00;
			end
		end
	end

	// alarms and relays
	always_comb begin
		fv           = i_fault;
		fv[FB_CLOW]  = lo;
		fv[FB_CHIGH] = hi;
		fv[FB_VAL1]  = vflag[0];
		fv[FB_VAL2]  = vflag[1];
		fv[FB_SCRUB] = scrub;
		fv[FB_ANY]   = 1'b0;
		any_flt      = |fv;
		fv[FB_ANY]   = any_flt;

		next_hi    = gen_rst_p ? 1'b0 : hi;
		next_lo    = gen_rst_p ? 1'b0 : lo;
		if (avg_upd) begin
			next_hi = o_avg > cfg.high_sp;
			next_lo = o_avg < cfg.low_sp;
		end
		// scrubber fault, condition wins over clear
		next_scrub = (scrub & ~scrub_new_p & ~gen_rst_p) |
			(i_scrub_pct <= SCRUB_PCT) | (i_scrub_days == 16'h0000);
		next_vflag = (vflag & ~{2{vcancel_p | gen_rst_p}}) | i_val_fail;
		next_glat = (glat & ~gen_rst_p) | any_flt;
		if (cfg.gmode == GM_NONL) begin
			next_gen_relay = ~any_flt;
		end else begin
			next_gen_relay = ~next_glat;
		end
		next_assign_relay = (|(cfg.do_setup[31:1] & fv[31:1])) ^
			cfg.do_setup[0];

		sts_set            = '0;
		sts_set[ST_HIGH]   = next_hi & ~hi;
		sts_set[ST_LOW]    = next_lo & ~lo;
		sts_set[ST_SCRUB]  = next_scrub & ~scrub;
		sts_set[ST_VSTART] = next_val_start;
		sts_set[ST_KPTO]   = next_kp_to;
		sts_set[ST_GDROP]  = o_gen_relay & ~next_gen_relay;
		next_sts = sts;
		if (we && aarc_hit(i_addr, OFS_STAT)) begin
			next_sts = sts & ~i_wdata[ST_W-1:0];
		end
		// a new event beats a clear in the same cycle
		next_sts = next_sts | sts_set;
	end

	// register reads, data valid the cycle after the strobe only
	always_comb begin
		next_rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				OFS_CTRL: begin
					next_rdata[CTRL_DVAL]   = cfg.daily_en;
					next_rdata[CTRL_GM+:2]  = cfg.gmode;
					next_rdata[CTRL_PM+:2]  = cfg.proto;
				end
				OFS_DOSET: next_rdata = cfg.do_setup;
				OFS_HIGH:  next_rdata[CW-1:0] = cfg.high_sp;
				OFS_LOW:   next_rdata[CW-1:0] = cfg.low_sp;
				OFS_AVGL:  next_rdata[2:0] = cfg.avg_log;
				OFS_WDOG:  next_rdata[7:0] = cfg.wdog;
				OFS_NODE:  next_rdata[7:0] = cfg.node;
				OFS_VSCH: begin
					next_rdata[7:0]          = cfg.val_int;
					next_rdata[VSCH_ST+:11]  = cfg.val_start;
				end
				OFS_TIME:  next_rdata[10:0] = tod;
				OFS_STAT:  next_rdata[ST_W-1:0] = sts;
				OFS_MASK:  next_rdata[ST_W-1:0] = irq_mask;
				OFS_FLT:   next_rdata = fv;
				OFS_AVG:   next_rdata[15:0] = o_avg;
				default:   next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg.daily_en  <= 1'b0;
			cfg.gmode     <= GM_LATCH;
			cfg.proto     <= PM_OFF;
			cfg.do_setup  <= DOSET_RST;
			cfg.high_sp   <= '1;
			cfg.low_sp    <= '0;
			cfg.avg_log   <= AVGL_RST;
			cfg.wdog      <= WDOG_RST;
			cfg.node      <= NODE_MIN;
			cfg.val_int   <= 8'h01;
			cfg.val_start <= 11'h000;
			irq_mask      <= '0;
			psc           <= 32'h0000_0000;
			sec           <= 6'h00;
			tod           <= 11'h000;
			days          <= 8'h00;
			wd            <= 8'h00;
		end else if (i_ce) begin
			cfg      <= next_cfg;
			irq_mask <= next_irq_mask;
			psc      <= next_psc;
			sec      <= next_sec;
			tod      <= next_tod;
			days     <= next_days;
			wd       <= next_wd;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hi              <= 1'b0;
			lo              <= 1'b0;
			scrub           <= 1'b0;
			vflag           <= 2'h0;
			glat            <= 1'b0;
			sts             <= '0;
			o_rdata         <= '0;
			o_assign_relay  <= 1'b0;
			o_gen_relay     <= 1'b0;
			o_val_start     <= 1'b0;
			o_kp_timeout    <= 1'b0;
			o_scrub_restart <= 1'b0;
			o_req_ack       <= 1'b0;
			o_generic_out   <= 1'b1;
			o_rtu_variant   <= 1'b0;
			o_irq           <= 1'b0;
		end else if (i_ce) begin
			hi              <= next_hi;
			lo              <= next_lo;
			scrub           <= next_scrub;
			vflag           <= next_vflag;
			glat            <= next_glat;
			sts             <= next_sts;
			o_rdata         <= next_rdata;
			o_assign_relay  <= next_assign_relay;
			o_gen_relay     <= next_gen_relay;
			o_val_start     <= next_val_start;
			o_kp_timeout    <= next_kp_to;
			o_scrub_restart <= scrub_new_p;
			o_req_ack       <= i_req.vld && cfg.proto != PM_OFF &&
				i_req.node == cfg.node && aarc_fc_ok(i_req.func);
			o_generic_out   <= cfg.proto == PM_OFF;
			o_rtu_variant   <= cfg.proto == PM_RTU_B;
			o_irq           <= |(next_sts & next_irq_mask);
		end
	end
endmodule // aarc_top
`default_nettype wire

// ==== verif/aarc_chk_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module aarc_chk #(
	parameter int unsigned P_CYC_PER_SEC = 4
) (
	input  wire logic                    i_core_clk,
	input  wire logic                    i_rst_b,
	input  wire logic                    i_ce,
	input  wire logic [aarc_pkg::AW-1:0] i_addr,
	input  wire logic [aarc_pkg::DW-1:0] i_wdata,
	input  wire logic                    i_wr,
	input  wire logic                    i_rd,
	input  wire logic [31:0]             i_fault,
	input  wire logic                    i_smp_vld,
	input  wire logic                    i_on_menu,
	input  wire aarc_pkg::aarc_req_t     i_req,
	input  wire logic [aarc_pkg::DW-1:0] o_rdata,
	input  wire logic                    o_gen_relay,
	input  wire logic [15:0]             o_avg,
	input  wire logic                    o_val_start,
	input  wire logic                    o_kp_timeout,
	input  wire logic                    o_scrub_restart,
	input  wire logic                    o_req_ack,
	input  wire logic                    o_generic_out,
	input  wire logic                    o_rtu_variant
);
	import aarc_pkg::*;
	logic        ctrl_wr, avgl_wr, scrub_cmd, req_ok;
	logic [31:0] menu_run;
	assign ctrl_wr   = i_wr & i_ce & (i_addr == OFS_CTRL);
	assign avgl_wr   = i_wr & i_ce & (i_addr == OFS_AVGL);
	assign scrub_cmd = i_wr & i_ce & (i_addr == OFS_CMD) & i_wdata[CMD_SCRUB];
	assign req_ok    = i_ce & i_req.vld & (i_req.node >= NODE_MIN)
		& (i_req.node <= NODE_MAX) & ((i_req.func == FC_RD)
		| (i_req.func == FC_WR1) | (i_req.func == FC_WRN));
	// menu visit length; keeps counting under ce low, so only a lower bound
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			menu_run <= '0;
		end else begin
			menu_run <= i_on_menu ? menu_run + 32'h1 : '0;
		end
	end
	default clocking dck @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	// a frozen block keeps its read data, so only enabled edges count
	rdata_idle_a: assert property ($past(i_ce) && !$past(i_rd) |->
		o_rdata == '0)
		else $error("read data outside its slot");
	proto_write_a: assert property ($changed(o_generic_out) |->
		$past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("protocol output changed without a write");
	rtu_excl_a: assert property (o_rtu_variant |-> !o_generic_out)
		else $error("variant select while generic output");
	ack_cause_a: assert property (o_req_ack |-> $past(req_ok))
		else $error("answer without a valid request");
	val_pulse_a: assert property (o_val_start && i_ce |=>
		!o_val_start)
		else $error("validation start longer than one cycle");
	kp_menu_a: assert property (o_kp_timeout |->
		menu_run >= 32'(4 * P_CYC_PER_SEC))
		else $error("keypad timeout too early");
	scrub_pulse_a: assert property (o_scrub_restart |->
		$past(scrub_cmd) || $past(scrub_cmd, 2))
		else $error("scrubber restart without command");
	power_drop_a: assert property (i_fault[0] && i_ce ##1 i_fault[0]
		|=> !o_gen_relay)
		else $error("general relay energized on power fail");
	avg_cause_a: assert property ($changed(o_avg) |-> $past(i_smp_vld)
		|| $past(avgl_wr) || $past(avgl_wr, 2))
		else $error("average changed without a sample");
	cover property (o_req_ack);
	cover property (o_kp_timeout);
	cover property (o_val_start);
	cover property (o_scrub_restart);
endmodule // aarc_chk
`default_nettype wire

// ==== verif/aarc_serial_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module aarc_serial_master (
	input  wire logic                i_core_clk,
	input  wire logic                i_rst_b,
	input  wire logic                i_go,
	input  wire logic [7:0]          i_node,
	input  wire logic [7:0]          i_func,
	input  wire logic                i_req_ack,
	output var  aarc_pkg::aarc_req_t o_req,
	output logic      [7:0]          o_acks
);
	import aarc_pkg::*;
	// idle fields toggle so a stale address can never pass for a request
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_req  <= '0;
			o_acks <= '0;
		end else begin
			o_req.vld  <= i_go;
			o_req.node <= i_go ? i_node : ~o_req.node;
			o_req.func <= i_go ? i_func : ~o_req.func;
			o_acks     <= o_acks + {7'h0, i_req_ack};
		end
	end
endmodule // aarc_serial_master
`default_nettype wire

// ==== verif/test_analyzer_alarm_relay_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_analyzer_alarm_relay_control;
	import aarc_pkg::*;
	localparam int unsigned CPS = 4;
	logic          i_core_clk = 1'b0;
	logic          i_rst_b = 1'b0;
	logic          i_ce = 1'b1;
	logic [AW-1:0] i_addr = '0;
	logic [DW-1:0] i_wdata = '0;
	logic          i_wr = 1'b0;
	logic          i_rd = 1'b0;
	logic [31:0]   i_fault = '0;
	logic          i_smp_vld = 1'b0;
	logic [15:0]   i_smp = '0;
	logic [7:0]    i_scrub_pct = 8'h50;
	logic [15:0]   i_scrub_days = 16'h0100;
	logic [1:0]    i_val_fail = '0;
	logic          i_on_menu = 1'b0;
	aarc_req_t     i_req;
	logic [DW-1:0] o_rdata, v;
	logic          o_assign_relay, o_gen_relay, o_val_start, o_kp_timeout;
	logic          o_scrub_restart, o_req_ack, o_generic_out, o_rtu_variant;
	logic          o_irq, go = 1'b0, p;
	logic [15:0]   o_avg, sq[$];
	logic [7:0]    node = '0, func = '0, acks;
	logic [1:0]    pc;
	int            fails = 0, checks_done = 0, b, n;
	logic [7:0]    ra [9] = '{OFS_CTRL, OFS_DOSET, OFS_HIGH, OFS_LOW,
		OFS_AVGL, OFS_WDOG, OFS_NODE, OFS_CMD, 8'h3C};
	logic [31:0]   rv [9] = '{32'h0, DOSET_RST, 32'hFFFF, 32'h0,
		{29'h0, AVGL_RST}, {24'h0, WDOG_RST}, {24'h0, NODE_MIN}, 32'h0, 32'h0};

	aarc_top #(.P_CYC_PER_SEC(CPS)) dut (.i_core_clk, .i_rst_b, .i_ce,
		.i_addr, .i_wdata, .i_wr, .i_rd, .i_fault, .i_smp_vld, .i_smp,
		.i_scrub_pct, .i_scrub_days, .i_val_fail, .i_on_menu, .i_req,
		.o_rdata, .o_assign_relay, .o_gen_relay, .o_avg, .o_val_start,
		.o_kp_timeout, .o_scrub_restart, .o_req_ack, .o_generic_out,
		.o_rtu_variant, .o_irq);
	aarc_serial_master u_master (.i_core_clk, .i_rst_b, .i_go(go),
		.i_node(node), .i_func(func), .i_req_ack(o_req_ack),
		.o_req(i_req), .o_acks(acks));

	always #25 i_core_clk = ~i_core_clk;

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// outputs are looked at on the falling edge, well clear of updates
	task automatic cyc(input int k);
		repeat (k) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		d = o_rdata;
	endtask
	task automatic feed(input logic [15:0] s);
		@(posedge i_core_clk);
		i_smp     <= s;
		i_smp_vld <= 1'b1;
		@(posedge i_core_clk);
		i_smp_vld <= 1'b0;
	endtask
	task automatic req(input logic [7:0] nd, fc, input logic [7:0] exp);
		logic [7:0] a0;
		a0 = acks;
		@(posedge i_core_clk);
		node <= nd;
		func <= fc;
		go   <= 1'b1;
		@(posedge i_core_clk);
		go <= 1'b0;
		cyc(4);
		chk("serial answers", acks - a0, {24'h0, exp});
	endtask
	task automatic wp(input int sel, lim, input bit must, output int k);
		k = 0;
		while (k < lim && (sel ? o_val_start : o_kp_timeout) !== 1'b1) begin
			@(negedge i_core_clk);
			k++;
		end
		if (must && k == lim) begin
			fails++;
			$display("ERROR pulse wait expected 1 seen 0");
			summarize();
		end
	endtask
	function automatic logic [15:0] mean(input logic [15:0] q[$]);
		logic [17:0] s;
		s = '0;
		foreach (q[k])
			s += 18'(q[k]);
		return 16'(s / 18'(q.size()));
	endfunction

	initial begin
		repeat (20000) @(posedge i_core_clk);
		fails++;
		summarize();
	end

	initial begin
		v = $urandom(32'h535E);
		repeat (3) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		for (int k = 0; k < 9; k++) begin
			rd(ra[k], v);
			chk("reset value", v, rv[k]);
		end
		// a write while the clock enable is low must leave no trace
		@(posedge i_core_clk);
		i_ce <= 1'b0;
		wr(OFS_LOW, 32'h7);
		@(posedge i_core_clk);
		i_ce <= 1'b1;
		rd(OFS_LOW, v);
		chk("frozen write", v, 0);
		chk("gen relay idle", o_gen_relay, 1);
		chk("generic output", o_generic_out, 1);
		@(posedge i_core_clk);
		i_fault <= 32'h1;
		cyc(3);
		chk("gen relay drop", o_gen_relay, 0);
		@(posedge i_core_clk);
		i_fault <= '0;
		cyc(3);
		chk("gen relay held", o_gen_relay, 0);
		wr(OFS_CTRL, {29'h0, GM_RESET, 1'b0});
		cyc(3);
		chk("gen relay reset", o_gen_relay, 1);
		rd(OFS_CTRL, v);
		chk("mode restored", v, 0);
		wr(OFS_CTRL, 32'h2);
		for (int k = 0; k < 6; k++) begin
			b = 2 + $urandom % 30;
			if (b inside {12, 13, 20, 21, 27})
				b = 9;
			p = 1'($urandom);
			wr(OFS_DOSET, (32'h1 << b) | {31'h0, p});
			@(posedge i_core_clk);
			i_fault <= 32'h1 << b;
			cyc(3);
			chk("assign relay trip", o_assign_relay, !p);
			chk("gen relay fault", o_gen_relay, 0);
			@(posedge i_core_clk);
			i_fault <= '0;
			cyc(3);
			chk("assign relay rest", o_assign_relay, p);
			chk("gen relay back", o_gen_relay, 1);
		end
		wr(OFS_CTRL, 32'hA);
		wr(OFS_NODE, 32'h0);
		wr(OFS_NODE, 32'hFB);
		rd(OFS_NODE, v);
		chk("node refused", v, 1);
		wr(OFS_NODE, 32'hFA);
		rd(OFS_NODE, v);
		chk("node top", v, 32'hFA);
		chk("generic off", o_generic_out, 0);
		req(8'hFA, FC_RD, 1);
		req(8'hFA, FC_WR1, 1);
		req(8'hFA, FC_WRN, 1);
		req(8'hFA, 8'h05, 0);
		req(8'h07, FC_RD, 0);
		wr(OFS_CTRL, 32'h12);
		cyc(2);
		chk("rtu variant", o_rtu_variant, 1);
		req(8'hFA, FC_WRN, 1);
		wr(OFS_CTRL, 32'h2);
		cyc(2);
		chk("generic on", o_generic_out, 1);
		req(8'hFA, FC_RD, 0);
		wr(OFS_HIGH, 32'h64);
		wr(OFS_LOW, 32'h32);
		wr(OFS_AVGL, 32'h0);
		feed(16'hC8);
		cyc(3);
		chk("avg of one", o_avg, 16'hC8);
		rd(OFS_FLT, v);
		chk("conc high", v[FB_CHIGH], 1);
		wr(OFS_MASK, 32'h1);
		cyc(2);
		chk("irq raised", o_irq, 1);
		wr(OFS_STAT, 32'h3F);
		cyc(2);
		chk("irq cleared", o_irq, 0);
		feed(16'hA);
		cyc(3);
		rd(OFS_FLT, v);
		chk("conc low", {v[FB_CLOW], v[FB_CHIGH]}, 2'b10);
		chk("irq masked", o_irq, 0);
		wr(OFS_HIGH, 32'hFFFF);
		wr(OFS_LOW, 32'h0);
		wr(OFS_AVGL, 32'h2);
		repeat (4) begin
			sq.push_back(16'($urandom));
			feed(sq[$]);
		end
		cyc(3);
		chk("avg of four", o_avg, mean(sq));
		@(posedge i_core_clk);
		i_scrub_pct <= SCRUB_PCT;
		cyc(3);
		rd(OFS_FLT, v);
		chk("scrub capacity", v[FB_SCRUB], 1);
		// clear the capacity fault first, or the days check proves nothing
		@(posedge i_core_clk);
		i_scrub_pct <= 8'h50;
		wr(OFS_CMD, 32'h1);
		rd(OFS_FLT, v);
		chk("scrub pct gone", v[FB_SCRUB], 0);
		@(posedge i_core_clk);
		i_scrub_days <= 16'h0;
		cyc(3);
		rd(OFS_FLT, v);
		chk("scrub days", v[FB_SCRUB], 1);
		@(posedge i_core_clk);
		i_scrub_days <= 16'h0100;
		wr(OFS_CMD, 32'h1);
		pc = '0;
		repeat (3) begin
			@(negedge i_core_clk);
			pc += {1'b0, o_scrub_restart};
		end
		chk("restart pulse", pc, 1);
		rd(OFS_FLT, v);
		chk("scrub cleared", v[FB_SCRUB], 0);
		@(posedge i_core_clk);
		i_val_fail <= 2'b11;
		@(posedge i_core_clk);
		i_val_fail <= 2'b00;
		cyc(2);
		rd(OFS_FLT, v);
		chk("val flags", {v[FB_VAL2], v[FB_VAL1]}, 2'b11);
		wr(OFS_CMD, 32'h2);
		cyc(2);
		rd(OFS_FLT, v);
		chk("val flags gone", {v[FB_VAL2], v[FB_VAL1]}, 2'b00);
		rd(OFS_CMD, v);
		chk("command reads zero", v, 0);
		wr(OFS_WDOG, {24'h0, WDOG_MIN});
		@(posedge i_core_clk);
		i_on_menu <= 1'b1;
		wp(0, 200, 1, n);
		chk("watchdog time", n > 5*CPS-4 && n < 5*CPS+4, 1);
		@(posedge i_core_clk);
		i_on_menu <= 1'b0;
		wr(OFS_WDOG, 32'h4);
		@(posedge i_core_clk);
		i_on_menu <= 1'b1;
		wp(0, 60, 0, n);
		chk("watchdog off", n, 60);
		wr(OFS_VSCH, 32'h201);
		wr(OFS_TIME, 32'h1);
		wr(OFS_CTRL, 32'h3);
		wp(1, 80*CPS, 1, n);
		chk("validation time", n > 55*CPS, 1);
		wr(OFS_TIME, 32'h1);
		wr(OFS_CTRL, 32'h2);
		wp(1, 80*CPS, 0, n);
		chk("validation off", n, 80*CPS);
		summarize();
	end
endmodule // test_analyzer_alarm_relay_control
bind aarc_top aarc_chk #(.P_CYC_PER_SEC(P_CYC_PER_SEC)) u_chk (.i_core_clk,
	.i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_fault, .i_smp_vld,
	.i_on_menu, .i_req, .o_rdata, .o_gen_relay, .o_avg, .o_val_start,
	.o_kp_timeout, .o_scrub_restart, .o_req_ack, .o_generic_out,
	.o_rtu_variant);
`default_nettype wire
